/* File: design/bidir_port.sv */
// 16-bit double-buffered bidirectional handshake port
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
module bidir_port (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [15:0] port_pins_i,
    output logic [15:0] port_pins_o,
    output logic [15:0] port_pins_oe_o,
    input wire logic output_ack_in_i,
    input wire logic input_strobe_in_i,
    output logic output_ready_out_o,
    output logic input_ready_out_o,
    output logic dma_request_out_o,
    output logic service_request_o
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [1:0] ack_s1;
        logic [1:0] ack_s2;
        logic [1:0] stb_s1;
        logic [1:0] stb_s2;
        logic [15:0] pin_s1;
        logic [15:0] pin_s2;
        logic ack_prev;
        logic stb_prev;
        logic [7:0] gen_ctrl;
        logic [7:0] svc_ctrl;
        logic [7:0] a_ctrl;
        logic [7:0] b_ctrl;
        logic [7:0] a_hold;
        logic [15:0] initial_output_latch;
        logic initial_output_full;
        logic [15:0] final_output_latch;
        logic final_output_full;
        logic [15:0] iil;
        logic iil_full;
        logic [15:0] final_input_latch;
        logic final_input_full;
        logic [2:0] out_pcnt;
        logic out_pdone;
        logic [2:0] in_pcnt;
        logic in_pdone;
        logic [7:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic ack_lvl;
    logic stb_lvl;
    logic ack_rise;
    logic stb_rise;
    logic out_en;
    logic in_en;
    logic out_rdy_cond;
    logic in_rdy_cond;
    logic out_rdy;
    logic in_rdy;
    logic [7:0] status;
    logic b_data_wr;
    logic b_data_rd;

    assign rst_n = rst_sync_q[1];
    // level sync of handshake inputs; only the second stage is read
    assign ack_lvl = s_q.ack_s2[1];
    assign stb_lvl = s_q.stb_s2[1];
    assign ack_rise = ack_lvl & ~s_q.ack_prev;
    assign stb_rise = stb_lvl & ~s_q.stb_prev;
    assign out_en = s_q.gen_ctrl[bidir_port_pkg::GEN_OUT_PAIR_EN];
    assign in_en = s_q.gen_ctrl[bidir_port_pkg::GEN_IN_PAIR_EN];
    assign b_data_wr = reg_wr_i & (reg_addr_i == bidir_port_pkg::ADDR_B_DATA);
    assign b_data_rd = reg_rd_i & (reg_addr_i == bidir_port_pkg::ADDR_B_DATA);

    // ************************************************************
    // handshake outputs
    // ************************************************************
    // ready conditions; the edge drops ready in the cycle it is seen, but the pins
    // pass a long synchroniser, so the negation trails the pin by several cycles
    assign out_rdy_cond = s_q.final_output_full;
    assign in_rdy_cond = ~(s_q.iil_full & s_q.final_input_full);
    always_comb begin
        out_rdy = out_en & out_rdy_cond & ~ack_rise;
        if (s_q.a_ctrl[bidir_port_pkg::CTL_PULSED]) begin
            out_rdy = out_rdy & ~s_q.out_pdone;
        end
        in_rdy = in_en & in_rdy_cond & ~stb_rise;
        if (s_q.b_ctrl[bidir_port_pkg::CTL_PULSED]) begin
            in_rdy = in_rdy & ~s_q.in_pdone;
        end
    end

    // status: both ready status bits always read zero
    always_comb begin
        status = 8'h00;
        status[bidir_port_pkg::ST_OUT_ACK] = s_q.a_ctrl[bidir_port_pkg::CTL_STAT_SEL] ?
            ~(s_q.initial_output_full | s_q.final_output_full) :
            ~(s_q.initial_output_full & s_q.final_output_full);
        status[bidir_port_pkg::ST_IN_STB] = s_q.final_input_full;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.ack_s1 = {s_q.ack_s1[0], output_ack_in_i};
        s_d.ack_s2 = {s_q.ack_s2[0], s_q.ack_s1[1]};
        s_d.stb_s1 = {s_q.stb_s1[0], input_strobe_in_i};
        s_d.stb_s2 = {s_q.stb_s2[0], s_q.stb_s1[1]};
        s_d.pin_s1 = port_pins_i;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.ack_prev = ack_lvl;
        s_d.stb_prev = stb_lvl;
        // output pulse timer restarts whenever the enable or the ready condition falls away, or on an acknowledge edge
        if (!(out_en & out_rdy_cond) || ack_rise) begin
            s_d.out_pcnt = 3'h0;
            s_d.out_pdone = 1'b0;
        end else if (!s_q.out_pdone) begin
            s_d.out_pcnt = s_q.out_pcnt + 3'h1;
            s_d.out_pdone = (s_q.out_pcnt + 3'h1) >= bidir_port_pkg::PULSE_CYC;
        end
        if (!(in_en & in_rdy_cond) || stb_rise) begin
            s_d.in_pcnt = 3'h0;
            s_d.in_pdone = 1'b0;
        end else if (!s_q.in_pdone) begin
            s_d.in_pcnt = s_q.in_pcnt + 3'h1;
            s_d.in_pdone = (s_q.in_pcnt + 3'h1) >= bidir_port_pkg::PULSE_CYC;
        end
        // acknowledge counts while data is held; a pulse that has ended still allows it
        if (ack_rise && out_en && s_q.final_output_full) begin
            s_d.final_output_full = 1'b0;
        end
        // queued word moves up as soon as the final latch frees
        if (!s_d.final_output_full && s_q.initial_output_full) begin
            s_d.final_output_latch = s_q.initial_output_latch;
            s_d.final_output_full = 1'b1;
            s_d.initial_output_full = 1'b0;
        end
        // port b write carries the held high byte with it
        if (b_data_wr) begin
            if (!s_d.final_output_full) begin
                s_d.final_output_latch = {s_q.a_hold, reg_wdata_i};
                s_d.final_output_full = 1'b1;
            end else if (!s_d.initial_output_full) begin
                s_d.initial_output_latch = {s_q.a_hold, reg_wdata_i};
                s_d.initial_output_full = 1'b1;
            end
        end
        // port b read frees the final input latch
        if (b_data_rd) begin
            s_d.final_input_full = s_q.iil_full;
            s_d.final_input_latch = s_q.iil;
            s_d.iil_full = 1'b0;
        end
        // strobes are ignored while both input latches are full
        if (stb_rise && in_en && in_rdy_cond) begin
            if (!s_d.final_input_full) begin
                s_d.final_input_latch = s_q.pin_s2;
                s_d.final_input_full = 1'b1;
            end else begin
                s_d.iil = s_q.pin_s2;
                s_d.iil_full = 1'b1;
            end
        end
        // register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                bidir_port_pkg::ADDR_GEN_CTRL: s_d.gen_ctrl = reg_wdata_i;
                bidir_port_pkg::ADDR_SVC_CTRL: s_d.svc_ctrl = reg_wdata_i;
                bidir_port_pkg::ADDR_A_CTRL: s_d.a_ctrl = reg_wdata_i;
                bidir_port_pkg::ADDR_B_CTRL: s_d.b_ctrl = reg_wdata_i;
                bidir_port_pkg::ADDR_A_DATA: s_d.a_hold = reg_wdata_i;
                default: ;
            endcase
        end
        // read data, one cycle later; unmapped reads give zero
        s_d.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                bidir_port_pkg::ADDR_GEN_CTRL: s_d.rdata = s_q.gen_ctrl;
                bidir_port_pkg::ADDR_SVC_CTRL: s_d.rdata = s_q.svc_ctrl;
                bidir_port_pkg::ADDR_A_CTRL: s_d.rdata = s_q.a_ctrl;
                bidir_port_pkg::ADDR_B_CTRL: s_d.rdata = s_q.b_ctrl;
                bidir_port_pkg::ADDR_A_DATA: s_d.rdata = s_q.final_input_latch[15:8];
                bidir_port_pkg::ADDR_B_DATA: s_d.rdata = s_q.final_input_latch[7:0];
                bidir_port_pkg::ADDR_STATUS: s_d.rdata = status;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // reset synchroniser kept out of the state: it alone runs on the raw reset
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // everything else on the synchronised reset
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q.ack_s1 <= 2'b00;
            s_q.ack_s2 <= 2'b00;
            s_q.stb_s1 <= 2'b00;
            s_q.stb_s2 <= 2'b00;
            s_q.pin_s1 <= 16'h0000;
            s_q.pin_s2 <= 16'h0000;
            s_q.ack_prev <= 1'b0;
            s_q.stb_prev <= 1'b0;
            s_q.gen_ctrl <= bidir_port_pkg::CTRL_RESET;
            s_q.svc_ctrl <= bidir_port_pkg::CTRL_RESET;
            s_q.a_ctrl <= bidir_port_pkg::CTRL_RESET;
            s_q.b_ctrl <= bidir_port_pkg::CTRL_RESET;
            s_q.a_hold <= 8'h00;
            s_q.initial_output_latch <= 16'h0000;
            s_q.initial_output_full <= 1'b0;
            s_q.final_output_latch <= 16'h0000;
            s_q.final_output_full <= 1'b0;
            s_q.iil <= 16'h0000;
            s_q.iil_full <= 1'b0;
            s_q.final_input_latch <= 16'h0000;
            s_q.final_input_full <= 1'b0;
            s_q.out_pcnt <= 3'h0;
            s_q.out_pdone <= 1'b0;
            s_q.in_pcnt <= 3'h0;
            s_q.in_pdone <= 1'b0;
            s_q.rdata <= 8'h00;
        end else begin
            s_q.ack_s1 <= s_d.ack_s1;
            s_q.ack_s2 <= s_d.ack_s2;
            s_q.stb_s1 <= s_d.stb_s1;
            s_q.stb_s2 <= s_d.stb_s2;
            s_q.pin_s1 <= s_d.pin_s1;
            s_q.pin_s2 <= s_d.pin_s2;
            s_q.ack_prev <= s_d.ack_prev;
            s_q.stb_prev <= s_d.stb_prev;
            s_q.gen_ctrl <= s_d.gen_ctrl;
            s_q.svc_ctrl <= s_d.svc_ctrl;
            s_q.a_ctrl <= s_d.a_ctrl;
            s_q.b_ctrl <= s_d.b_ctrl;
            s_q.a_hold <= s_d.a_hold;
            s_q.initial_output_latch <= s_d.initial_output_latch;
            s_q.initial_output_full <= s_d.initial_output_full;
            s_q.final_output_latch <= s_d.final_output_latch;
            s_q.final_output_full <= s_d.final_output_full;
            s_q.iil <= s_d.iil;
            s_q.iil_full <= s_d.iil_full;
            s_q.final_input_latch <= s_d.final_input_latch;
            s_q.final_input_full <= s_d.final_input_full;
            s_q.out_pcnt <= s_d.out_pcnt;
            s_q.out_pdone <= s_d.out_pdone;
            s_q.in_pcnt <= s_d.in_pcnt;
            s_q.in_pdone <= s_d.in_pdone;
            s_q.rdata <= s_d.rdata;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // drivers follow the synced acknowledge level, not the direction registers
    assign port_pins_o = s_q.final_output_latch;
    assign port_pins_oe_o = {16{~ack_lvl}};
    assign output_ready_out_o = out_rdy;
    assign input_ready_out_o = in_rdy;
    assign reg_rdata_o = s_q.rdata;
    // dma source is a single select, so it can never follow both directions
    assign dma_request_out_o = s_q.svc_ctrl[bidir_port_pkg::SVC_DMA_OUT] ?
        (s_q.a_ctrl[bidir_port_pkg::CTL_SVC_EN] & status[bidir_port_pkg::ST_OUT_ACK]) :
        (s_q.b_ctrl[bidir_port_pkg::CTL_SVC_EN] & s_q.final_input_full);
    // service request: strobe/ack status when enabled, ready interrupts when enabled
    assign service_request_o =
        (s_q.b_ctrl[bidir_port_pkg::CTL_SVC_EN] & s_q.final_input_full) |
        (s_q.a_ctrl[bidir_port_pkg::CTL_SVC_EN] & status[bidir_port_pkg::ST_OUT_ACK]) |
        (s_q.b_ctrl[bidir_port_pkg::CTL_RDY_IRQ_EN] & in_rdy) |
        (s_q.a_ctrl[bidir_port_pkg::CTL_RDY_IRQ_EN] & out_rdy);

    // ************************************************************
    // checks
    // ************************************************************
    property p_oe_follows_ack;
        @(posedge clk_sys_i) disable iff (!rst_n)
        port_pins_oe_o == {16{~$past(s_q.ack_s1[0], 3)}};
    endproperty
    a_oe_follows_ack: assert property (p_oe_follows_ack) else $error("oe mismatch");
    property p_out_rdy_en;
        @(posedge clk_sys_i) disable iff (!rst_n)
        !out_en |-> !output_ready_out_o;
    endproperty
    a_out_rdy_en: assert property (p_out_rdy_en) else $error("out ready while disabled");
    property p_in_rdy_en;
        @(posedge clk_sys_i) disable iff (!rst_n)
        !in_en |-> !input_ready_out_o;
    endproperty
    a_in_rdy_en: assert property (p_in_rdy_en) else $error("in ready while disabled");
    property p_out_pulse_len;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (s_q.a_ctrl[bidir_port_pkg::CTL_PULSED] && output_ready_out_o)[*4] |=> !output_ready_out_o;
    endproperty
    a_out_pulse_len: assert property (p_out_pulse_len) else $error("out pulse too long");
    property p_in_pulse_len;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (s_q.b_ctrl[bidir_port_pkg::CTL_PULSED] && input_ready_out_o)[*4] |=> !input_ready_out_o;
    endproperty
    a_in_pulse_len: assert property (p_in_pulse_len) else $error("in pulse too long");
    property p_stb_status;
        @(posedge clk_sys_i) disable iff (!rst_n)
        $rose(s_q.final_input_full) |-> $past(stb_rise) || $past(b_data_rd);
    endproperty
    a_stb_status: assert property (p_stb_status) else $error("input status set without cause");
    property p_out_drop;
        @(posedge clk_sys_i) disable iff (!rst_n)
        ack_rise |-> !output_ready_out_o;
    endproperty
    a_out_drop: assert property (p_out_drop) else $error("ready not dropped on ack");
    property p_in_full;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (s_q.iil_full && s_q.final_input_full) |-> !input_ready_out_o;
    endproperty
    a_in_full: assert property (p_in_full) else $error("in ready while full");
    property p_write_pair;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (b_data_wr && !s_q.final_output_full && !s_q.initial_output_full) |=>
            s_q.final_output_latch[15:8] == $past(s_q.a_hold);
    endproperty
    a_write_pair: assert property (p_write_pair) else $error("high byte not paired");
endmodule

/* File: inc/bidir_port_pkg.sv */
// package: register map, field positions and timing for the 16-bit bidirectional port
package bidir_port_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_GEN_CTRL = 4'h0; // general port control
    localparam logic [3:0] ADDR_SVC_CTRL = 4'h1; // dma routing select
    localparam logic [3:0] ADDR_A_CTRL = 4'h6;
    localparam logic [3:0] ADDR_B_CTRL = 4'h7;
    localparam logic [3:0] ADDR_A_DATA = 4'h8;
    localparam logic [3:0] ADDR_B_DATA = 4'h9;
    localparam logic [3:0] ADDR_STATUS = 4'ha;
    // general control fields
    localparam int GEN_OUT_PAIR_EN = 4;
    localparam int GEN_IN_PAIR_EN = 5;
    // service control: 1 routes dma to output transfers
    localparam int SVC_DMA_OUT = 0;
    // port control fields (same layout for a and b)
    localparam int CTL_STAT_SEL = 0;
    localparam int CTL_SVC_EN = 1;
    localparam int CTL_RDY_IRQ_EN = 2;
    localparam int CTL_PULSED = 3;
    // status fields
    localparam int ST_OUT_ACK = 0;
    localparam int ST_OUT_RDY = 1;
    localparam int ST_IN_STB = 2;
    localparam int ST_IN_RDY = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // pulsed handshake length
    localparam int PULSE_NS = 40;
    localparam int CLK_NS = 10;
    localparam logic [2:0] PULSE_CYC = 3'(PULSE_NS / CLK_NS);

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] dout;
        logic out_oe;
        logic out_rdy;
        logic in_rdy;
        logic dma_req;
        logic svc_req;
    } port_out_t;
endpackage

/* File: test/periph_model.sv */
// peripheral model facing the handshake pins of the bidirectional port
`timescale 1ns/1ps
module periph_model (
    input wire logic clk_sys_i,
    input wire logic out_rdy_i,
    input wire logic in_rdy_i,
    input wire logic [15:0] bus_i,
    input wire logic [3:0] slow_i,
    output logic ack_o,
    output logic stb_o,
    output logic [15:0] pins_o,
    output logic taken_o,
    output logic [15:0] taken_data_o
);
    logic rdy_seen;

    // idle: acknowledge high so the port bus is ours, strobe low
    initial begin
        ack_o = 1'b1;
        stb_o = 1'b0;
        pins_o = 16'h0000;
        taken_o = 1'b0;
        taken_data_o = 16'h0000;
        rdy_seen = 1'b0;
    end

    // remember a ready pulse, a pulsed ready may be gone before we look
    always @(posedge clk_sys_i) begin
        if (stb_o)
            rdy_seen <= 1'b0;
        else if (in_rdy_i)
            rdy_seen <= 1'b1;
    end

    // answer output ready: release the bus, wait, take the word, acknowledge
    always @(posedge clk_sys_i) begin
        if (out_rdy_i && ack_o) begin
            ack_o <= 1'b0;
            // the drivers turn on four edges after the fall, so look one edge later
            repeat (5 + slow_i) @(posedge clk_sys_i);
            taken_data_o <= bus_i;
            taken_o <= 1'b1;
            ack_o <= 1'b1;
            @(posedge clk_sys_i);
            taken_o <= 1'b0;
            repeat (3) @(posedge clk_sys_i);
        end
    end

    // one input word; rude strobes without waiting for ready
    task automatic send(input logic [15:0] d, input logic rude);
        int n;
        n = 0;
        while (!rude && !rdy_seen && n < 300) begin
            @(posedge clk_sys_i);
            n++;
        end
        @(posedge clk_sys_i);
        pins_o <= d;
        repeat (3) @(posedge clk_sys_i);
        stb_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        stb_o <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        // hold time over: stale data must not look valid
        pins_o <= ~d;
    endtask
endmodule

/* File: test/tb_bidir_16bit_handshake_port.sv */
// self-checking testbench for the 16-bit bidirectional handshake port
`timescale 1ns/1ps
module tb_bidir_16bit_handshake_port;
    logic clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i, tgl, ack, stb, taken, rd_s;
    logic out_rdy, in_rdy, dma, svc;
    logic [3:0] reg_addr_i, slow;
    logic [7:0] reg_wdata_i, reg_rdata_o, gen_m, a_ctl_m, b_ctl_m;
    logic [7:0] ack_h = 8'h55;
    logic [15:0] port_pins_o, oe, pins_w, pm_pins, taken_d;
    logic [15:0] w [6];
    logic [31:0] seed;
    logic [15:0] rd_q [$];
    logic [15:0] out_q [$];
    int failures = 0;
    int n_checks = 0;
    int irun = 0;
    int orun = 0;

    // bus level: device, peripheral, or a moving pattern when nobody drives
    assign pins_w = (oe & port_pins_o) | (~oe & (ack ? pm_pins : 16'h5a5a ^ {16{tgl}}));

    bidir_port dut_u (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .port_pins_i(pins_w),
        .port_pins_o(port_pins_o), .port_pins_oe_o(oe), .output_ack_in_i(ack), .input_strobe_in_i(stb),
        .output_ready_out_o(out_rdy), .input_ready_out_o(in_rdy), .dma_request_out_o(dma),
        .service_request_o(svc)
    );

    periph_model pm_u (
        .clk_sys_i(clk_sys_i), .out_rdy_i(out_rdy), .in_rdy_i(in_rdy), .bus_i(pins_w), .slow_i(slow),
        .ack_o(ack), .stb_o(stb), .pins_o(pm_pins), .taken_o(taken), .taken_data_o(taken_d)
    );

    // 100 MHz clock and a toggle for the floating bus pattern
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) tgl <= ~tgl;

    // ****************************************
    // shared tasks
    // ****************************************
    function automatic logic [15:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // strobes stay up between back-to-back accesses; cyc lowers them
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
        @(posedge clk_sys_i);
        if (a == bidir_port_pkg::ADDR_GEN_CTRL) gen_m = d;
        if (a == bidir_port_pkg::ADDR_A_CTRL) a_ctl_m = d;
        if (a == bidir_port_pkg::ADDR_B_CTRL) b_ctl_m = d;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        reg_wr_i <= 1'b0;
        rd_q.push_back({8'h00, e});
        @(posedge clk_sys_i);
    endtask

    task automatic cyc(input int n);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
    endtask

    // high byte first, the low byte write moves the word in
    task automatic put(input logic [15:0] d);
        wr(bidir_port_pkg::ADDR_A_DATA, d[15:8]);
        wr(bidir_port_pkg::ADDR_B_DATA, d[7:0]);
        out_q.push_back(d);
    endtask

    task automatic get(input logic [15:0] d);
        rd(bidir_port_pkg::ADDR_A_DATA, d[15:8]);
        rd(bidir_port_pkg::ADDR_B_DATA, d[7:0]);
    endtask

    // watcher: each result takes the oldest note; pins and ready pulses watched too
    always @(posedge clk_sys_i) begin
        rd_s = reg_rd_i;
        #1;
        if (rd_s) chk({8'h00, reg_rdata_o}, rd_q.pop_front());
        if (taken) chk(taken_d, out_q.pop_front());
        ack_h = rst_b_i ? {ack_h[6:0], ack} : 8'h55;
        if (ack_h == 8'h00 || ack_h == 8'hff) chk(oe, {16{~ack}});
        irun = in_rdy ? irun + 1 : 0;
        orun = out_rdy ? orun + 1 : 0;
        if ((b_ctl_m[3] && irun > 4) || (!gen_m[5] && in_rdy)) chk(16'h1, 16'h0);
        if ((a_ctl_m[3] && orun > 4) || (!gen_m[4] && out_rdy)) chk(16'h1, 16'h0);
    end

    // watchdog: the whole run needs a few hundred cycles
    initial begin
        #100us;
        failures++;
        final_report();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_b_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        tgl = 1'b0;
        slow = 4'h0;
        gen_m = 8'h00;
        a_ctl_m = 8'h00;
        b_ctl_m = 8'h00;
        seed = 32'h2cd6;
        for (int i = 0; i < 6; i++) w[i] = nxt();
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        cyc(3);
        // reset values, read-back, unmapped place; submode bits set but ignored
        rd(bidir_port_pkg::ADDR_GEN_CTRL, bidir_port_pkg::CTRL_RESET);
        rd(bidir_port_pkg::ADDR_B_CTRL, bidir_port_pkg::CTRL_RESET);
        rd(4'h3, 8'h00);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h01);
        wr(bidir_port_pkg::ADDR_B_CTRL, 8'hc0);
        rd(bidir_port_pkg::ADDR_B_CTRL, 8'hc0);
        wr(bidir_port_pkg::ADDR_A_CTRL, 8'hc0);
        // output pair off: words queue, status meanings, a third word refused
        put(w[0]);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h01);
        wr(bidir_port_pkg::ADDR_A_CTRL, 8'hc1);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h00);
        put(w[1]);
        wr(bidir_port_pkg::ADDR_A_DATA, 8'hff);
        wr(bidir_port_pkg::ADDR_B_DATA, 8'hff);
        wr(bidir_port_pkg::ADDR_A_CTRL, 8'hc0);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h00);
        slow <= 4'(nxt());
        wr(bidir_port_pkg::ADDR_GEN_CTRL, 8'h10);
        cyc(80);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h01);
        // pulsed output, words back to back, ready status stays clear
        wr(bidir_port_pkg::ADDR_GEN_CTRL, 8'h00);
        wr(bidir_port_pkg::ADDR_A_CTRL, 8'hc8);
        wr(bidir_port_pkg::ADDR_GEN_CTRL, 8'h10);
        put(w[2]);
        put(w[3]);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h00);
        cyc(80);
        // interlocked input: two words, a third strobe while full is ignored
        wr(bidir_port_pkg::ADDR_GEN_CTRL, 8'h00);
        wr(bidir_port_pkg::ADDR_A_CTRL, 8'hc0);
        wr(bidir_port_pkg::ADDR_SVC_CTRL, 8'h00);
        wr(bidir_port_pkg::ADDR_GEN_CTRL, 8'h30);
        cyc(4);
        chk(16'(in_rdy), 16'h1);
        pm_u.send(w[4], 1'b0);
        pm_u.send(w[5], 1'b0);
        pm_u.send(16'h0ff0, 1'b1);
        cyc(2);
        chk(16'(in_rdy), 16'h0);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h05);
        // request gating and routing
        wr(bidir_port_pkg::ADDR_B_CTRL, 8'hc2);
        cyc(2);
        chk({14'h0, dma, svc}, 16'h3);
        wr(bidir_port_pkg::ADDR_SVC_CTRL, 8'h01);
        cyc(2);
        chk(16'(dma), 16'h0);
        wr(bidir_port_pkg::ADDR_A_CTRL, 8'hc2);
        cyc(2);
        chk(16'(dma), 16'h1);
        wr(bidir_port_pkg::ADDR_A_CTRL, 8'hc0);
        wr(bidir_port_pkg::ADDR_SVC_CTRL, 8'h00);
        wr(bidir_port_pkg::ADDR_B_CTRL, 8'hc0);
        cyc(2);
        chk({14'h0, dma, svc}, 16'h0);
        get(w[4]);
        get(w[5]);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h01);
        wr(bidir_port_pkg::ADDR_B_CTRL, 8'hc4);
        cyc(4);
        chk({14'h0, in_rdy, svc}, 16'h3);
        // pulsed input
        wr(bidir_port_pkg::ADDR_GEN_CTRL, 8'h10);
        wr(bidir_port_pkg::ADDR_B_CTRL, 8'hc8);
        wr(bidir_port_pkg::ADDR_GEN_CTRL, 8'h30);
        cyc(1);
        pm_u.send(w[0], 1'b0);
        pm_u.send(w[1], 1'b0);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h05);
        get(w[0]);
        get(w[1]);
        rd(bidir_port_pkg::ADDR_STATUS, 8'h01);
        cyc(20);
        chk(16'(rd_q.size() + out_q.size()), 16'h0);
        final_report();
    end
endmodule
